// ### gfm_pkg.sv
// Package of register offsets, field positions, reset values and counts.
package gfm_pkg;
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_RESULT_LOW = 3'h3;
  localparam logic [2:0] ADDR_RESULT_MID = 3'h4;
  localparam logic [2:0] ADDR_RESULT_HIGH = 3'h5;
  localparam logic [2:0] ADDR_GATE_SET = 3'h6;

  // Fields of counter_control_one.
  localparam int START_LSB = 0;
  localparam int CLEAR_BIT = 2;
  localparam int SRC_LSB = 4;
  // Fields of counter_control_two.
  localparam int GSEL_LSB = 0;
  localparam int EDGE_BIT = 2;
  localparam int BOTH_BIT = 3;
  localparam int GCLK_LSB = 4;
  localparam int ROUTE_BIT = 6;
  localparam int DIVSEL_BIT = 7;
  // Fields of counter_status_reg and gate_setting_reg.
  localparam int STAT_GATE_BIT = 7;
  localparam int STAT_OVF_BIT = 6;
  localparam int HIGH_LSB = 4;
  localparam int LOW_LSB = 0;

  // Writable bits of counter_control_one: start field and source select.
  localparam logic [7:0] CTRL_ONE_MASK = 8'h33;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] GATE_SET_RESET = 8'h00;

  localparam int COUNT_W = 18;
  localparam logic [17:0] COUNT_RESET = 18'h00000;
  localparam logic [1:0] START_STOP = 2'h0;
  localparam logic [1:0] GSEL_EXT = 2'h0;
  localparam logic [1:0] GSEL_OTHER = 2'h1;
  localparam logic [1:0] GSEL_INTERNAL = 2'h2;

  // Gate period is (16 - setting) units.
  localparam logic [4:0] PERIOD_BASE = 5'h10;
  // Unit lengths in system clock cycles (fast) and slow clock cycles.
  localparam int FAST_UNIT0 = 4096;
  localparam logic [6:0] SLOW_UNIT0 = 7'h10;
  localparam logic [6:0] SLOW_UNIT1 = 7'h20;
  localparam logic [6:0] SLOW_UNIT2 = 7'h40;
endpackage

// ### gate_window_gen.sv
// Internal window gate generator with programmable high and low periods.
`timescale 1ns/1ps
module gate_window_gen #(
  parameter int FAST_UNIT1 = 8192,
  parameter int FAST_UNIT2 = 16384
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_use_slow,
  input wire logic i_slow_tick,
  input wire logic [1:0] i_unit_sel,
  input wire logic [3:0] i_high_set,
  input wire logic [3:0] i_low_set,
  output logic o_gate
);
  typedef enum logic [1:0] {GATE_IDLE, GATE_HIGH, GATE_LOW} gate_state_t;

  gate_state_t state;
  gate_state_t next_state;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [14:0] div_cnt;
  logic [6:0] slow_cnt;
  logic [14:0] fast_mask;
  logic [6:0] slow_mask;
  logic unit_tick;

  // The unit tick is taken from a free running divider, so the first
  // period after start may come up to one unit late.
  always_comb begin
    unique case (i_unit_sel)
      2'h0: begin
        fast_mask = 15'(gfm_pkg::FAST_UNIT0 - 1);
        slow_mask = gfm_pkg::SLOW_UNIT0 - 7'h01;
      end
      2'h1: begin
        fast_mask = 15'(FAST_UNIT1 - 1);
        slow_mask = gfm_pkg::SLOW_UNIT1 - 7'h01;
      end
      default: begin
        fast_mask = 15'(FAST_UNIT2 - 1);
        slow_mask = gfm_pkg::SLOW_UNIT2 - 7'h01;
      end
    endcase
    if (i_use_slow) begin
      unit_tick = i_slow_tick && ((slow_cnt & slow_mask) == slow_mask);
    end else begin
      unit_tick = (div_cnt & fast_mask) == fast_mask;
    end
  end

  // High is counting time, low is stop time; each setting is latched when
  // its period begins, so a low write during low waits a period.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (!i_run) begin
      next_state = GATE_IDLE;
      next_cnt = 5'h00;
    end else if (unit_tick) begin
      unique case (state)
        GATE_IDLE: begin
          next_state = GATE_HIGH;
          next_cnt = gfm_pkg::PERIOD_BASE - {1'b0, i_high_set};
        end
        GATE_HIGH: begin
          if (cnt == 5'h01) begin
            next_state = GATE_LOW;
            next_cnt = gfm_pkg::PERIOD_BASE - {1'b0, i_low_set};
          end else begin
            next_cnt = cnt - 5'h01;
          end
        end
        GATE_LOW: begin
          if (cnt == 5'h01) begin
            next_state = GATE_HIGH;
            next_cnt = gfm_pkg::PERIOD_BASE - {1'b0, i_high_set};
          end else begin
            next_cnt = cnt - 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state <= GATE_IDLE;
      cnt <= 5'h00;
      div_cnt <= 15'h0000;
      slow_cnt <= 7'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      div_cnt <= div_cnt + 15'h0001;
      slow_cnt <= i_slow_tick ? slow_cnt + 7'h01 : slow_cnt;
    end
  end

  assign o_gate = (state == GATE_HIGH);

  high_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    $rose(o_gate) |-> cnt == 5'(gfm_pkg::PERIOD_BASE - {1'b0, $past(i_high_set)}))
    else $error("High period not loaded from its setting.");

  stop_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_run |=> !o_gate)
    else $error("Internal gate high while stopped.");
endmodule // gate_window_gen

// ### gated_frequency_meter.sv
// Gated frequency meter: 18-bit counter of pulses inside a window gate.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module gated_frequency_meter #(
  parameter int FAST_UNIT1 = 8192,
  parameter int FAST_UNIT2 = 16384
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_measured_pulse_input,
  input wire logic i_external_gate_input,
  input wire logic i_other_timer_pulse_out,
  input wire logic i_slow_clock,
  output logic o_timer_interrupt,
  output logic o_shared_port_pin,
  output logic o_shared_port_pin_oe
);
  logic [2:0] pin_raw;
  logic [2:0] sync_meta;
  logic [2:0] sync_q;
  logic slow_prev;
  logic slow_tick;

  logic [7:0] counter_control_one;
  logic [7:0] counter_control_two;
  logic [7:0] gate_setting_reg;
  logic [17:0] count;
  logic overflow_monitor;
  logic gate_q;
  logic pulse_q;
  logic and_q;
  logic [7:0] next_counter_control_one;
  logic [7:0] next_counter_control_two;
  logic [7:0] next_gate_setting_reg;
  logic [17:0] next_count;
  logic next_overflow_monitor;
  logic [7:0] next_rdata;
  logic next_timer_interrupt;

  logic running;
  logic clear_req;
  logic internal_gate;
  logic gate_sel;
  logic gate_now;
  logic gate_fall;
  logic gate_rise;
  logic pulse_now;
  logic and_now;
  logic [1:0] inc;
  logic [18:0] sum;

  assign pin_raw = {i_slow_clock, i_external_gate_input,
                    i_measured_pulse_input};

  // Two-stage synchronisers for the pins.
  generate
    for (genvar k = 0; k < 3; k++) begin : g_sync
      always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
          sync_meta[k] <= 1'b0;
          sync_q[k] <= 1'b0;
        end else begin
          sync_meta[k] <= pin_raw[k];
          sync_q[k] <= sync_meta[k];
        end
      end
    end
  endgenerate

  assign slow_tick = sync_q[2] && !slow_prev;
  assign pulse_now = sync_q[0];
  assign running =
    counter_control_one[gfm_pkg::START_LSB +: 2] != gfm_pkg::START_STOP;
  assign clear_req = i_wr && (i_addr == gfm_pkg::ADDR_CTRL_ONE) &&
                     i_wdata[gfm_pkg::CLEAR_BIT];

  gate_window_gen #(
    .FAST_UNIT1(FAST_UNIT1),
    .FAST_UNIT2(FAST_UNIT2)
  ) u_gate_gen (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_run(running),
    .i_use_slow(counter_control_two[gfm_pkg::DIVSEL_BIT]),
    .i_slow_tick(slow_tick),
    .i_unit_sel(counter_control_two[gfm_pkg::GCLK_LSB +: 2]),
    .i_high_set(gate_setting_reg[gfm_pkg::HIGH_LSB +: 4]),
    .i_low_set(gate_setting_reg[gfm_pkg::LOW_LSB +: 4]),
    .o_gate(internal_gate)
  );

  // Gate selection and event detection.
  always_comb begin
    unique case (counter_control_two[gfm_pkg::GSEL_LSB +: 2])
      gfm_pkg::GSEL_EXT: gate_sel = sync_q[1];
      gfm_pkg::GSEL_OTHER: gate_sel = i_other_timer_pulse_out;
      gfm_pkg::GSEL_INTERNAL: gate_sel = internal_gate;
      default: gate_sel = 1'b0;
    endcase
    gate_now = running && gate_sel;
    gate_fall = gate_q && !gate_now;
    gate_rise = !gate_q && gate_now;
    and_now = pulse_now && gate_now;
    if (counter_control_two[gfm_pkg::BOTH_BIT]) begin
      inc = {1'b0, gate_now && (pulse_now ^ pulse_q)} +
            {1'b0, gate_fall};
    end else begin
      inc = {1'b0, and_q && !and_now};
    end
    sum = {1'b0, count} + {17'h00000, inc};
  end

  // Next values of registers, counter and status.
  always_comb begin
    next_counter_control_one = counter_control_one;
    next_counter_control_two = counter_control_two;
    next_gate_setting_reg = gate_setting_reg;
    if (i_wr) begin
      unique case (i_addr)
        gfm_pkg::ADDR_CTRL_ONE:
          next_counter_control_one = i_wdata & gfm_pkg::CTRL_ONE_MASK;
        gfm_pkg::ADDR_CTRL_TWO: next_counter_control_two = i_wdata;
        gfm_pkg::ADDR_GATE_SET: next_gate_setting_reg = i_wdata;
        default: next_gate_setting_reg = gate_setting_reg;
      endcase
    end
    if (clear_req) begin
      next_count = {16'h0000, inc};
      next_overflow_monitor = 1'b0;
    end else begin
      next_count = sum[17:0];
      next_overflow_monitor = overflow_monitor || sum[18];
    end
    next_timer_interrupt = gate_fall ||
      (counter_control_two[gfm_pkg::EDGE_BIT] && gate_rise);
    next_rdata = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        gfm_pkg::ADDR_CTRL_ONE: next_rdata = counter_control_one;
        gfm_pkg::ADDR_CTRL_TWO: next_rdata = counter_control_two;
        gfm_pkg::ADDR_STATUS: begin
          next_rdata[gfm_pkg::STAT_GATE_BIT] = gate_q;
          next_rdata[gfm_pkg::STAT_OVF_BIT] = overflow_monitor;
        end
        gfm_pkg::ADDR_RESULT_LOW: next_rdata = count[7:0];
        gfm_pkg::ADDR_RESULT_MID: next_rdata = count[15:8];
        gfm_pkg::ADDR_RESULT_HIGH: next_rdata = {6'h00, count[17:16]};
        gfm_pkg::ADDR_GATE_SET: next_rdata = gate_setting_reg;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      slow_prev <= 1'b0;
      counter_control_one <= gfm_pkg::CTRL_ONE_RESET;
      counter_control_two <= gfm_pkg::CTRL_TWO_RESET;
      gate_setting_reg <= gfm_pkg::GATE_SET_RESET;
      count <= gfm_pkg::COUNT_RESET;
      overflow_monitor <= 1'b0;
      gate_q <= 1'b0;
      pulse_q <= 1'b0;
      and_q <= 1'b0;
      o_rdata <= 8'h00;
      o_timer_interrupt <= 1'b0;
      o_shared_port_pin <= 1'b0;
      o_shared_port_pin_oe <= 1'b0;
    end else begin
      slow_prev <= sync_q[2];
      counter_control_one <= next_counter_control_one;
      counter_control_two <= next_counter_control_two;
      gate_setting_reg <= next_gate_setting_reg;
      count <= next_count;
      overflow_monitor <= next_overflow_monitor;
      gate_q <= gate_now;
      pulse_q <= pulse_now;
      and_q <= and_now;
      o_rdata <= next_rdata;
      o_timer_interrupt <= next_timer_interrupt;
      // The route bit only gates the pin; it never steers the other timer.
      o_shared_port_pin <= !counter_control_two[gfm_pkg::ROUTE_BIT] &&
                           i_other_timer_pulse_out;
      o_shared_port_pin_oe <= !counter_control_two[gfm_pkg::ROUTE_BIT];
    end
  end

  default clocking main_cb @(posedge i_sys_clk);
  endclocking

  default disable iff (!i_resetn);

  sequence gate_fall_s;
    gate_q && !gate_now;
  endsequence

  sequence gate_rise_s;
    !gate_q && gate_now;
  endsequence

  sequence wrap_s;
    count == 18'h3FFFF && inc != 2'h0 && !clear_req;
  endsequence

  fall_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    gate_fall_s |=> o_timer_interrupt)
    else $error("No interrupt after gate fall.");

  rise_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    gate_rise_s |=> o_timer_interrupt == $past(counter_control_two[2]))
    else $error("Gate rise interrupt disagrees with edge select.");

  ovf_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    wrap_s |=> overflow_monitor && count < 18'h00002)
    else $error("Counter wrap did not set overflow.");

  ovf_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    overflow_monitor && !clear_req |=> overflow_monitor)
    else $error("Overflow monitor dropped without a clear.");

  count_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !gate_q && !gate_now && !clear_req |=> $stable(count))
    else $error("Counter moved while gate low.");

  ext_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    running && counter_control_two[1:0] == 2'h0 |-> gate_now == sync_q[1])
    else $error("External gate not used with select 00.");

  const_fall_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    gate_fall_s ##0 (counter_control_two[3] && pulse_now == pulse_q &&
    !clear_req) |=> count == $past(count) + 18'h00001)
    else $error("Gate fall did not add one count.");

  status_rd_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_rd && i_addr == 3'h2 |=> o_rdata[7] == $past(gate_q) &&
    o_rdata[6] == $past(overflow_monitor))
    else $error("Status read does not show gate and overflow.");

  route_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    counter_control_two[6] |=> !o_shared_port_pin_oe && !o_shared_port_pin)
    else $error("Pin driven with route bit set.");

  stop_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !running |=> !gate_q)
    else $error("Gate status high while stopped.");

  clear_cnt_a: assert property (
    clear_req |=> count < 18'h00003 && !overflow_monitor)
    else $error("Counter clear did not reset count and overflow.");

  single_fall_a: assert property (
    !counter_control_two[3] && and_q && !and_now && !clear_req &&
    count != 18'h3FFFF |=> count == $past(count) + 18'h00001)
    else $error("Fall of input and gate did not add one count.");

  irq_quiet_a: assert property (
    !gate_fall && !gate_rise |=> !o_timer_interrupt)
    else $error("Interrupt without a gate edge.");

  route_on_a: assert property (
    !counter_control_two[6] |=> o_shared_port_pin_oe &&
    o_shared_port_pin == $past(i_other_timer_pulse_out))
    else $error("Pin not driven with route bit clear.");

  stop_count_a: assert property (
    !running && !gate_q && !clear_req |=> $stable(count))
    else $error("Counter moved while stopped.");

  sync_gate_a: assert property (
    sync_q[1] |-> $past(sync_meta[1]))
    else $error("Gate synchroniser skipped a stage.");
endmodule // gated_frequency_meter

// ### pulse_source.sv
// Model of the pulse source whose frequency is measured.
`timescale 1ns/1ps
module pulse_source (
  input wire logic i_sys_clk,
  input wire logic i_start,
  input wire logic [7:0] i_count,
  input wire logic i_slow,
  input wire logic i_idle,
  output logic o_pulse,
  output logic o_busy
);
  logic [7:0] left;
  logic [2:0] ph;
  initial begin
    left = 8'h00;
    ph = 3'h0;
  end
  // Pulses are high then low for 2 cycles each, or 4 when slow.
  always @(posedge i_sys_clk) begin
    if (i_start) begin
      left <= i_count;
      ph <= 3'h0;
    end else if (left != 8'h00) begin
      ph <= ph + 3'h1;
      if (ph == (i_slow ? 3'h7 : 3'h3)) begin
        left <= left - 8'h01;
        ph <= 3'h0;
      end
    end
  end
  assign o_busy = (left != 8'h00);
  assign o_pulse = o_busy ? ~(i_slow ? ph[2] : ph[1]) : i_idle;
endmodule // pulse_source

// ### gated_frequency_meter_tb_top.sv
// Self-checking bench for the gated frequency meter.
`timescale 1ns/1ps
module gated_frequency_meter_tb_top;
  logic clk;
  logic resetn;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic rd_en;
  logic [7:0] rdata;
  logic ext_gate;
  logic other;
  logic irq;
  logic pin;
  logic pin_oe;
  logic ps_start;
  logic [7:0] ps_cnt;
  logic ps_slow;
  logic ps_idle;
  logic pulse;
  logic busy;
  logic [7:0] d;
  logic [17:0] c;
  int errors;
  int total_checks;
  int cyc;
  int k;
  int t0;
  int stamps[$];

  always #10 clk = ~clk;

  gated_frequency_meter #(.FAST_UNIT1(16), .FAST_UNIT2(32)) dut_u (
    .i_sys_clk(clk),
    .i_resetn(resetn),
    .i_addr(addr),
    .i_wdata(wdata),
    .i_wr(wr_en),
    .i_rd(rd_en),
    .o_rdata(rdata),
    .i_measured_pulse_input(pulse),
    .i_external_gate_input(ext_gate),
    .i_other_timer_pulse_out(other),
    .i_slow_clock(1'b0),
    .o_timer_interrupt(irq),
    .o_shared_port_pin(pin),
    .o_shared_port_pin_oe(pin_oe)
  );

  pulse_source ps_u (
    .i_sys_clk(clk),
    .i_start(ps_start),
    .i_count(ps_cnt),
    .i_slow(ps_slow),
    .i_idle(ps_idle),
    .o_pulse(pulse),
    .o_busy(busy)
  );

  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) begin
      stamps.push_back(cyc);
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [17:0] s, e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic hang;
    errors++;
    $display("wrong value wait exp done seen timeout");
    end_sim();
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rdcnt(output logic [17:0] v);
    logic [7:0] lo;
    logic [7:0] mi;
    logic [7:0] hi;
    rd(3'h3, lo);
    rd(3'h4, mi);
    rd(3'h5, hi);
    v = {hi[1:0], mi, lo};
  endtask

  task automatic cfg(input logic [7:0] c2);
    wr(3'h0, 8'h10);
    wr(3'h1, c2);
    wr(3'h0, 8'h14);
    wr(3'h0, 8'h12);
    rd(3'h1, d);
    chk("ctrl two", d, c2);
  endtask

  task automatic send(input logic [7:0] n, input logic slow);
    @(posedge clk);
    ps_cnt <= n;
    ps_slow <= slow;
    ps_start <= 1'b1;
    @(posedge clk);
    ps_start <= 1'b0;
    @(posedge clk);
    for (int j = 0; j < 2000 && busy !== 1'b0; j++) @(posedge clk);
    if (busy !== 1'b0) hang();
  endtask

  task automatic gate(input bit oth, input logic v);
    @(posedge clk);
    if (oth) other <= v;
    else ext_gate <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic win(input bit oth, input logic [7:0] n, input logic lvl,
                     input logic [17:0] e, input int ei);
    k = stamps.size();
    @(posedge clk);
    ps_idle <= lvl;
    gate(oth, 1'b1);
    rd(3'h2, d);
    chk("gate high", d[7], 1'b1);
    send(n, n[0]);
    gate(oth, 1'b0);
    rd(3'h2, d);
    chk("gate low", d[7], 1'b0);
    rdcnt(c);
    chk("count", c, e);
    chk("irqs", 18'(stamps.size() - k), 18'(ei));
  endtask

  task automatic wait_irq(input int n);
    for (int j = 0; j < 1000 && stamps.size() < n; j++) @(posedge clk);
    if (stamps.size() < n) hang();
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    ext_gate = 1'b0;
    other = 1'b0;
    ps_start = 1'b0;
    ps_cnt = 8'h00;
    ps_slow = 1'b0;
    ps_idle = 1'b0;
    errors = 0;
    total_checks = 0;
    cyc = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), d);
      chk("reset value", d, 18'h00000);
    end
    wr(3'h0, 8'hFF);
    rd(3'h0, d);
    chk("ctrl one", d, gfm_pkg::CTRL_ONE_MASK);
    wr(3'h7, 8'hFF);
    rd(3'h7, d);
    chk("unmapped", d, 18'h00000);
    cfg(8'h00);
    @(posedge clk);
    other <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pin on", {pin, pin_oe}, 18'h00003);
    other <= 1'b0;
    send(8'h03, 1'b0);
    win(0, 8'h05, 1'b0, 18'h00005, 1);
    win(0, 8'h03, 1'b0, 18'h00008, 1);
    wr(3'h0, 8'h16);
    rdcnt(c);
    chk("cleared", c, 18'h00000);
    rd(3'h2, d);
    chk("no overflow", d[6], 1'b0);
    win(0, 8'h00, 1'b1, 18'h00001, 1);
    cfg(8'h0C);
    win(0, 8'h00, 1'b0, 18'h00001, 2);
    win(0, 8'h03, 1'b0, 18'h00008, 2);
    cfg(8'h41);
    win(1, 8'h02, 1'b0, 18'h00002, 1);
    @(posedge clk);
    other <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pin off", {pin, pin_oe}, 18'h00000);
    other <= 1'b0;
    wr(3'h0, 8'h10);
    wr(3'h6, 8'hEC);
    cfg(8'h16);
    t0 = cyc;
    k = stamps.size();
    wait_irq(k + 2);
    wr(3'h6, 8'hEE);
    wait_irq(k + 5);
    chk("first gate", 18'(stamps[k] - t0 <= 24), 18'h00001);
    chk("high", 18'(stamps[k+1] - stamps[k]), 18'h00020);
    chk("low", 18'(stamps[k+2] - stamps[k+1]), 18'h00040);
    chk("new low", 18'(stamps[k+4] - stamps[k+3]), 18'h00020);
    end_sim();
  end
endmodule // gated_frequency_meter_tb_top
